/* File: verilog/besp_defs.vh */
`ifndef BESP_DEFS_VH
`define BESP_DEFS_VH

// Configuration offsets, byte addresses of aligned dwords
`define BESP_STATUS_OFF        8'h68
`define BESP_OPTION_OFF        8'h74
`define BESP_ADDR_W            8

// Cause status field: eight sticky flags in bits 23:16
`define BESP_CAUSE_LSB         16
`define BESP_CAUSE_MSB         23
`define BESP_CAUSE_W           8
`define BESP_CAUSE_ADDR_PAR    0
`define BESP_CAUSE_PW_PAR      1
`define BESP_CAUSE_PW_NODLV    2
`define BESP_CAUSE_PW_TABORT   3
`define BESP_CAUSE_PW_MABORT   4
`define BESP_CAUSE_DW_NODLV    5
`define BESP_CAUSE_DR_NODATA   6
`define BESP_CAUSE_DT_TIMEOUT  7
`define BESP_CAUSE_RESET       8'h00
`define BESP_CAUSE_LANE        2

// Port option field positions
`define BESP_OPT_PRI_RD_ALIAS  1
`define BESP_OPT_PRI_WR_ALIAS  2
`define BESP_OPT_SEC_RD_ALIAS  3
`define BESP_OPT_SEC_WR_ALIAS  4
`define BESP_OPT_LONG_REQ      9
`define BESP_OPT_SEC_HOLD_REQ  10
`define BESP_OPT_PRI_HOLD_REQ  11
`define BESP_OPT_RESET         32'h0000_0C00
`define BESP_OPT_WR_MASK       32'h0000_0E1E

// Bus commands used by retry matching
`define BESP_CMD_W             4
`define BESP_CMD_MEM_RD        4'h6
`define BESP_CMD_MEM_WR        4'h7
`define BESP_CMD_MEM_RD_MULT   4'hC
`define BESP_CMD_MEM_RD_LINE   4'hE
`define BESP_CMD_MEM_WR_INV    4'hF

// Request holding state machine
`define BESP_RQ_IDLE           2'b00
`define BESP_RQ_ASK            2'b01
`define BESP_RQ_HOLD           2'b10

`endif

/* File: verilog/besp_cmd_match.v */
`timescale 1ns/1ps
`default_nettype none
`include "besp_defs.vh"

module besp_cmd_match (
    input  wire                      clk_in,
    input  wire                      rst_in,
    input  wire                      rd_alias_en_in,
    input  wire                      wr_alias_en_in,
    input  wire                      retry_valid_in,
    input  wire [`BESP_CMD_W-1:0]    retry_cmd_in,
    input  wire [`BESP_CMD_W-1:0]    queued_cmd_in,
    output reg                       match_valid_out,
    output reg                       match_out
);

    // Line and multiple reads are the only read aliases of a plain read
    function is_read_alias;
        input [`BESP_CMD_W-1:0] cmd;
        begin
            is_read_alias = (cmd == `BESP_CMD_MEM_RD_LINE) ||
                            (cmd == `BESP_CMD_MEM_RD_MULT);
        end
    endfunction

    wire exact_hit;
    wire rd_hit;
    wire wr_hit;

    // Exact compare always applies; aliases only widen the match
    assign exact_hit = (retry_cmd_in == queued_cmd_in);
    assign rd_hit    = rd_alias_en_in && (queued_cmd_in == `BESP_CMD_MEM_RD) &&
                       is_read_alias(retry_cmd_in);
    assign wr_hit    = wr_alias_en_in && (queued_cmd_in == `BESP_CMD_MEM_WR) &&
                       (retry_cmd_in == `BESP_CMD_MEM_WR_INV);

    // Result registered, one cycle after the retry is offered
    always @(posedge clk_in) begin
        if (rst_in) begin
            match_valid_out <= 1'b0;
            match_out       <= 1'b0;
        end else begin
            match_valid_out <= retry_valid_in;
            match_out       <= retry_valid_in && (exact_hit || rd_hit || wr_hit);
        end
    end

endmodule // besp_cmd_match

`default_nettype wire

/* File: verilog/besp_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "besp_defs.vh"

module besp_regs #(
    parameter NUM_PORTS = 2
) (
    input  wire                          clk_in,
    input  wire                          rst_in,
    // Configuration access
    input  wire                          cfg_wr_in,
    input  wire                          cfg_rd_in,
    input  wire [`BESP_ADDR_W-1:0]       cfg_addr_in,
    input  wire [3:0]                    cfg_be_in,
    input  wire [31:0]                   cfg_wdata_in,
    output reg  [31:0]                   cfg_rdata_out,
    output reg                           cfg_ack_out,
    // Error causes and their qualifiers
    input  wire [`BESP_CAUSE_W-1:0]      cause_event_in,
    input  wire [`BESP_CAUSE_W-1:0]      cause_disable_in,
    input  wire                          system_error_enable_in,
    output reg                           primary_system_error_n_out,
    output reg                           primary_system_error_oe_out,
    // Retry matching, index 0 primary, index 1 secondary
    input  wire [NUM_PORTS-1:0]          retry_valid_in,
    input  wire [NUM_PORTS*4-1:0]        retry_cmd_in,
    input  wire [NUM_PORTS*4-1:0]        queued_cmd_in,
    output wire [NUM_PORTS-1:0]          retry_match_valid_out,
    output wire [NUM_PORTS-1:0]          retry_match_out,
    // Internal master requests, index 0 primary, index 1 secondary
    input  wire [NUM_PORTS-1:0]          master_pending_in,
    input  wire [NUM_PORTS-1:0]          frame_start_in,
    input  wire [NUM_PORTS-1:0]          fifo_empty_in,
    input  wire [NUM_PORTS-1:0]          target_term_in,
    input  wire [NUM_PORTS-1:0]          lock_cycle_in,
    output wire [NUM_PORTS-1:0]          bus_req_n_out,
    output reg                           lock_long_request_out
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire                         hit_status;
    wire                         hit_option;
    wire                         wr_status;
    wire                         wr_option;
    wire [31:0]                  be_mask;

    // Low two address bits are ignored: every register is one dword
    assign hit_status = (cfg_addr_in[`BESP_ADDR_W-1:2] == `BESP_STATUS_OFF >> 2);
    assign hit_option = (cfg_addr_in[`BESP_ADDR_W-1:2] == `BESP_OPTION_OFF >> 2);
    assign wr_status  = cfg_wr_in && hit_status;
    assign wr_option  = cfg_wr_in && hit_option;

    // Byte enables widened to a bit mask
    assign be_mask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}},
                      {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};

    ////////////////////////////////////////////////////////////////////////////////////////
    // System error cause status

    reg  [`BESP_CAUSE_W-1:0]     cause_reg;
    reg  [`BESP_CAUSE_W-1:0]     cause_next;
    wire [`BESP_CAUSE_W-1:0]     cause_fire;
    wire [`BESP_CAUSE_W-1:0]     cause_clear;

    // A cause only counts once it really drives the pin
    assign cause_fire = cause_event_in & ~cause_disable_in &
                        {`BESP_CAUSE_W{system_error_enable_in}};

    // Ones written in the cause lane clear, zeros leave the flag alone
    assign cause_clear = (wr_status && cfg_be_in[`BESP_CAUSE_LANE]) ?
                         cfg_wdata_in[`BESP_CAUSE_MSB:`BESP_CAUSE_LSB] :
                         `BESP_CAUSE_RESET;

    // Set wins over a clear landing in the same cycle
    always @* begin
        cause_next = (cause_reg & ~cause_clear) | cause_fire;
    end

    // Individual flags kept sticky until software writes one
    always @(posedge clk_in) begin
        if (rst_in) begin
            cause_reg <= `BESP_CAUSE_RESET;
        end else begin
            cause_reg[`BESP_CAUSE_ADDR_PAR]   <= cause_next[`BESP_CAUSE_ADDR_PAR];
            cause_reg[`BESP_CAUSE_PW_PAR]     <= cause_next[`BESP_CAUSE_PW_PAR];
            cause_reg[`BESP_CAUSE_PW_NODLV]   <= cause_next[`BESP_CAUSE_PW_NODLV];
            cause_reg[`BESP_CAUSE_PW_TABORT]  <= cause_next[`BESP_CAUSE_PW_TABORT];
            cause_reg[`BESP_CAUSE_PW_MABORT]  <= cause_next[`BESP_CAUSE_PW_MABORT];
            cause_reg[`BESP_CAUSE_DW_NODLV]   <= cause_next[`BESP_CAUSE_DW_NODLV];
            cause_reg[`BESP_CAUSE_DR_NODATA]  <= cause_next[`BESP_CAUSE_DR_NODATA];
            cause_reg[`BESP_CAUSE_DT_TIMEOUT] <= cause_next[`BESP_CAUSE_DT_TIMEOUT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // System error pin

    // Open drain: the pin is only ever pulled low, never driven high.
    // One clock of drive per firing; repeated events give repeated pulses.
    always @(posedge clk_in) begin
        if (rst_in) begin
            primary_system_error_n_out  <= 1'b1;
            primary_system_error_oe_out <= 1'b0;
        end else begin
            primary_system_error_n_out  <= ~(|cause_fire);
            primary_system_error_oe_out <= |cause_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Port option control

    reg  [31:0]                  option_reg;
    reg  [31:0]                  option_next;
    wire [31:0]                  option_wmask;

    // Reserved bits never take a write, whatever the byte enables say
    assign option_wmask = be_mask & `BESP_OPT_WR_MASK;

    always @* begin
        option_next = option_reg;
        if (wr_option) begin
            option_next = (option_reg & ~option_wmask) | (cfg_wdata_in & option_wmask);
        end
    end

    // Hold-request bits come up set, alias and long-request bits clear
    always @(posedge clk_in) begin
        if (rst_in) begin
            option_reg <= `BESP_OPT_RESET;
        end else begin
            option_reg <= option_next & `BESP_OPT_WR_MASK;
        end
    end

    wire                         pri_rd_alias;
    wire                         pri_wr_alias;
    wire                         sec_rd_alias;
    wire                         sec_wr_alias;
    wire                         long_req_en;
    wire [NUM_PORTS-1:0]         hold_req_en;
    wire [NUM_PORTS-1:0]         rd_alias_en;
    wire [NUM_PORTS-1:0]         wr_alias_en;

    // Field extraction
    assign pri_rd_alias = option_reg[`BESP_OPT_PRI_RD_ALIAS];
    assign pri_wr_alias = option_reg[`BESP_OPT_PRI_WR_ALIAS];
    assign sec_rd_alias = option_reg[`BESP_OPT_SEC_RD_ALIAS];
    assign sec_wr_alias = option_reg[`BESP_OPT_SEC_WR_ALIAS];
    assign long_req_en  = option_reg[`BESP_OPT_LONG_REQ];

    // Per-port selections, primary in slot 0
    assign rd_alias_en = {sec_rd_alias, pri_rd_alias};
    assign wr_alias_en = {sec_wr_alias, pri_wr_alias};
    assign hold_req_en = {option_reg[`BESP_OPT_SEC_HOLD_REQ],
                          option_reg[`BESP_OPT_PRI_HOLD_REQ]};

    // Lock mode handed to the arbitration logic
    always @(posedge clk_in) begin
        if (rst_in) begin
            lock_long_request_out <= 1'b0;
        end else begin
            lock_long_request_out <= long_req_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Configuration read

    reg  [31:0]                  rdata_next;

    // Low half of the status dword belongs to clock control elsewhere: zero here
    always @* begin
        rdata_next = 32'h0000_0000;
        if (hit_status) begin
            rdata_next[`BESP_CAUSE_MSB:`BESP_CAUSE_LSB] = cause_reg;
        end else if (hit_option) begin
            rdata_next = option_reg;
        end
    end

    // Read data and acknowledge one cycle after the strobe
    always @(posedge clk_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 32'h0000_0000;
            cfg_ack_out   <= 1'b0;
        end else begin
            cfg_ack_out <= cfg_rd_in || cfg_wr_in;
            if (cfg_rd_in) begin
                cfg_rdata_out <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Per-port retry matching and request holding

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            reg  [1:0]           rq_state_reg;
            reg  [1:0]           rq_state_next;
            reg                  req_n_reg;
            wire                 keep_req;

            // Delayed transaction retries compared against the queued command
            besp_cmd_match u_match (
                .clk_in          (clk_in),
                .rst_in          (rst_in),
                .rd_alias_en_in  (rd_alias_en[p]),
                .wr_alias_en_in  (wr_alias_en[p]),
                .retry_valid_in  (retry_valid_in[p]),
                .retry_cmd_in    (retry_cmd_in[p*4 +: 4]),
                .queued_cmd_in   (queued_cmd_in[p*4 +: 4]),
                .match_valid_out (retry_match_valid_out[p]),
                .match_out       (retry_match_out[p])
            );

            // A locked cycle with long requests enabled holds as well
            assign keep_req = hold_req_en[p] ||
                              (long_req_en && lock_cycle_in[p]);

            // Release after frame start unless holding; holding ends on empty or stop
            always @* begin
                rq_state_next = rq_state_reg;
                case (rq_state_reg)
                    `BESP_RQ_IDLE: begin
                        if (master_pending_in[p]) begin
                            rq_state_next = `BESP_RQ_ASK;
                        end
                    end
                    `BESP_RQ_ASK: begin
                        if (frame_start_in[p]) begin
                            if (keep_req && !fifo_empty_in[p] && !target_term_in[p]) begin
                                rq_state_next = `BESP_RQ_HOLD;
                            end else begin
                                rq_state_next = `BESP_RQ_IDLE;
                            end
                        end
                    end
                    `BESP_RQ_HOLD: begin
                        if (fifo_empty_in[p] || target_term_in[p]) begin
                            rq_state_next = `BESP_RQ_IDLE;
                        end
                    end
                    default: begin
                        rq_state_next = `BESP_RQ_IDLE;
                    end
                endcase
            end

            // Request pin registered so it never glitches between states
            always @(posedge clk_in) begin
                if (rst_in) begin
                    rq_state_reg <= `BESP_RQ_IDLE;
                    req_n_reg    <= 1'b1;
                end else begin
                    rq_state_reg <= rq_state_next;
                    req_n_reg    <= (rq_state_next == `BESP_RQ_IDLE);
                end
            end

            assign bus_req_n_out[p] = req_n_reg;
        end
    endgenerate

endmodule // besp_regs

`default_nettype wire

/* File: verilog/besp_regs_end.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: tb/besp_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "besp_defs.vh"
module besp_regs_assertions #(
    parameter NUM_PORTS = 2
) (
    input wire logic                     clk_in,
    input wire logic                     rst_in,
    input wire logic                     cfg_wr_in,
    input wire logic                     cfg_rd_in,
    input wire logic [`BESP_ADDR_W-1:0]  cfg_addr_in,
    input wire logic [3:0]               cfg_be_in,
    input wire logic [31:0]              cfg_wdata_in,
    input wire logic [31:0]              cfg_rdata_out,
    input wire logic                     cfg_ack_out,
    input wire logic [`BESP_CAUSE_W-1:0] cause_event_in,
    input wire logic [`BESP_CAUSE_W-1:0] cause_disable_in,
    input wire logic                     system_error_enable_in,
    input wire logic                     primary_system_error_n_out,
    input wire logic                     primary_system_error_oe_out,
    input wire logic [NUM_PORTS-1:0]     retry_valid_in,
    input wire logic [NUM_PORTS*4-1:0]   retry_cmd_in,
    input wire logic [NUM_PORTS*4-1:0]   queued_cmd_in,
    input wire logic [NUM_PORTS-1:0]     retry_match_valid_out,
    input wire logic [NUM_PORTS-1:0]     retry_match_out,
    input wire logic [NUM_PORTS-1:0]     fifo_empty_in,
    input wire logic [NUM_PORTS-1:0]     target_term_in,
    input wire logic [NUM_PORTS-1:0]     bus_req_n_out,
    input wire logic                     lock_long_request_out
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (rst_in);
////////////////////////////////////////////////////////////////////////////////
// Qualified causes and option writes that reach bit 9
wire logic [7:0] fire_w = cause_event_in & ~cause_disable_in & {8{system_error_enable_in}};
wire logic       wr74_w = cfg_wr_in && cfg_addr_in[7:2] == 6'h1d && cfg_be_in[1];
////////////////////////////////////////////////////////////////////////////////
a_serr_on_cause: assert property ((|fire_w) |=>
    (!primary_system_error_n_out && primary_system_error_oe_out))
    else $error("pin not driven after qualified cause");
a_serr_held_off: assert property (!(|fire_w) |=>
    (primary_system_error_n_out && !primary_system_error_oe_out))
    else $error("pin driven without qualified cause");
a_status_spare_zero: assert property (
    cfg_ack_out && $past(cfg_rd_in && cfg_addr_in[7:2] == 6'h1a)
    |-> (cfg_rdata_out & 32'hff00_ffff) == 32'h0000_0000)
    else $error("status spare bits not zero");
a_option_spare_zero: assert property (
    cfg_ack_out && $past(cfg_rd_in && cfg_addr_in[7:2] == 6'h1d)
    |-> (cfg_rdata_out & ~32'h0000_0e1e) == 32'h0000_0000)
    else $error("option reserved bits not zero");
a_lock_from_write: assert property (!$stable(lock_long_request_out) |->
    ($past(wr74_w) && $past(cfg_wdata_in[9]) == lock_long_request_out) ||
    ($past(wr74_w, 2) && $past(cfg_wdata_in[9], 2) == lock_long_request_out))
    else $error("long request output changed without option write");
a_match_valid_next: assert property (retry_match_valid_out == $past(retry_valid_in))
    else $error("match valid not one cycle after offer");
a_exact_match: assert property (
    retry_valid_in[0] && retry_cmd_in[3:0] == queued_cmd_in[3:0] |=> retry_match_out[0])
    else $error("exact command did not match");
a_foreign_no_match: assert property (retry_valid_in[1] &&
    retry_cmd_in[7:4] != queued_cmd_in[7:4] && retry_cmd_in[7:4] < 4'hc
    |=> !retry_match_out[1])
    else $error("different command matched");
a_pri_req_release: assert property (
    !bus_req_n_out[0] && (fifo_empty_in[0] || target_term_in[0]) |=> bus_req_n_out[0])
    else $error("primary request held past drain");
a_sec_req_release: assert property (
    !bus_req_n_out[1] && (fifo_empty_in[1] || target_term_in[1]) |=> bus_req_n_out[1])
    else $error("secondary request held past drain");
endmodule // besp_regs_assertions
bind besp_regs besp_regs_assertions #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
    .cause_event_in(cause_event_in), .cause_disable_in(cause_disable_in),
    .system_error_enable_in(system_error_enable_in),
    .primary_system_error_n_out(primary_system_error_n_out),
    .primary_system_error_oe_out(primary_system_error_oe_out),
    .retry_valid_in(retry_valid_in), .retry_cmd_in(retry_cmd_in),
    .queued_cmd_in(queued_cmd_in), .retry_match_valid_out(retry_match_valid_out),
    .retry_match_out(retry_match_out), .fifo_empty_in(fifo_empty_in),
    .target_term_in(target_term_in), .bus_req_n_out(bus_req_n_out),
    .lock_long_request_out(lock_long_request_out));
`default_nettype wire

/* File: tb/besp_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module besp_far_side #(
    parameter DEPTH = 3
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [1:0] bus_req_n_in,
    input  wire logic       term_cmd_in,
    output var  logic [1:0] frame_start_out,
    output wire logic [1:0] fifo_empty_out,
    output wire logic [1:0] target_term_out
);
////////////////////////////////////////////////////////////////////////////////
// Per port: grant two cycles after request, burst of DEPTH words, wait for release
for (genvar p = 0; p < 2; p = p + 1) begin : g_port
    logic [2:0] ph;
    logic [3:0] cnt;
    // FIFO holds data until the burst drains, so a hold can really be seen
    assign fifo_empty_out[p]  = (ph == 3'h4) || (ph == 3'h3 && cnt == 4'h0);
    // Target stops the burst after one word, only when the bench commands it
    assign target_term_out[p] = term_cmd_in && ph == 3'h3 && cnt == DEPTH - 1;
    // No new grant until the request has been dropped
    always @(posedge clk_in) begin
        frame_start_out[p] <= 1'b0;
        if (rst_in) begin
            ph  <= 3'h0;
            cnt <= 4'h0;
        end else begin
            case (ph)
                3'h0: if (!bus_req_n_in[p]) ph <= 3'h1;
                3'h1: ph <= 3'h2;
                3'h2: begin
                    ph                 <= 3'h3;
                    cnt                <= DEPTH;
                    frame_start_out[p] <= 1'b1;
                end
                3'h3: if (target_term_out[p] || cnt == 4'h0) ph <= 3'h4; else cnt <= cnt - 1;
                default: if (bus_req_n_in[p]) ph <= 3'h0;
            endcase
        end
    end
end
endmodule // besp_far_side
`default_nettype wire

/* File: tb/bridge_error_status_port_options_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module bridge_error_status_port_options_test;
logic clk_in, rst_in, cfg_wr_in, cfg_rd_in, en, term;
logic [7:0]  cfg_addr_in, ev, dis, rc, qc;
logic [3:0]  cfg_be_in;
logic [31:0] cfg_wdata_in, rd_val, opt;
logic [1:0]  rv, pend, lock;
wire  [31:0] rdata;
wire         ack, serr_n, serr_oe, lockl;
wire  [1:0]  mv, mt, req_n, fs, fe, tt;
wire         serr_w = serr_oe ? serr_n : 1'b1; // Pull-up on the shared pin
int          n_mismatch, cmp_count, i, m, p;
besp_regs uut (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(rdata), .cfg_ack_out(ack),
    .cause_event_in(ev), .cause_disable_in(dis), .system_error_enable_in(en),
    .primary_system_error_n_out(serr_n), .primary_system_error_oe_out(serr_oe),
    .retry_valid_in(rv), .retry_cmd_in(rc), .queued_cmd_in(qc),
    .retry_match_valid_out(mv), .retry_match_out(mt), .master_pending_in(pend),
    .frame_start_in(fs), .fifo_empty_in(fe), .target_term_in(tt),
    .lock_cycle_in(lock), .bus_req_n_out(req_n), .lock_long_request_out(lockl));
besp_far_side far (.clk_in(clk_in), .rst_in(rst_in), .bus_req_n_in(req_n),
    .term_cmd_in(term), .frame_start_out(fs), .fifo_empty_out(fe), .target_term_out(tt));
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
end
task print_verdict;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
endtask
// One config access; strobe for one cycle, ack and data sampled a cycle later
task acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    begin
        @(negedge clk_in);
        {cfg_wr_in, cfg_rd_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = {w, !w, a, b, d};
        @(negedge clk_in);
        {cfg_wr_in, cfg_rd_in} = 2'b00;
        rd_val = rdata;
        `CHK(ack, 1'b1)
    end
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    begin
        acc(1'b0, a, 4'hf, 32'h0000_0000);
        `CHK(rd_val, e)
    end
endtask
task rt(input int pp, input logic [3:0] r, input logic [3:0] q, input logic e);
    begin
        @(negedge clk_in);
        rv[pp] = 1'b1;
        rc[pp*4 +: 4] = r;
        qc[pp*4 +: 4] = q;
        @(negedge clk_in);
        rv = 2'b00;
        `CHK(mv[pp], 1'b1)
        `CHK(mt[pp], e)
    end
endtask
// A limit that runs out is a mismatch and ends the run
task tmo(input int n, input int lim);
    if (n >= lim) begin
        n_mismatch++;
        print_verdict();
    end
endtask
// Request, grant, burst; checks cycles from frame start until the request drops against e
task rq(input int pp, input logic [31:0] o, input logic lk, input logic tm, input int e);
    int n;
    begin
        acc(1'b1, 8'h74, 4'hf, o);
        // Lock mode output trails the option register by one more clock
        @(negedge clk_in);
        `CHK(lockl, o[9])
        {lock[pp], term, pend[pp]} = {lk, tm, 1'b1};
        for (n = 0; req_n[pp] !== 1'b0 && n < 20; n++) @(negedge clk_in);
        tmo(n, 20);
        pend[pp] = 1'b0;
        for (n = 0; fs[pp] !== 1'b1 && n < 20; n++) @(negedge clk_in);
        tmo(n, 20);
        for (n = 0; req_n[pp] !== 1'b1 && n < 40; n++) @(negedge clk_in);
        `CHK(n, e)
        {lock, term} = 3'b000;
        repeat (8) @(negedge clk_in);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    {cfg_wr_in, cfg_rd_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = '0;
    {ev, dis, en, rv, rc, qc, pend, lock, term, n_mismatch, cmp_count} = '0;
    rst_in = 1'b1;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    rd(8'h68, 32'h0000_0000);
    rd(8'h74, 32'h0000_0c00);
    rd(8'h70, 32'h0000_0000);
    acc(1'b1, 8'h74, 4'hf, 32'hffff_ffff);
    rd(8'h74, 32'h0000_0e1e);
    $display("test reset_and_reserved done");
    // Each cause: qualified, disabled, and with the global enable off
    for (i = 0; i < 8; i++) begin
        for (m = 0; m < 3; m++) begin
            @(negedge clk_in);
            ev  = 8'h01 << i;
            dis = (m == 1) ? ev : 8'h00;
            en  = (m != 2);
            @(negedge clk_in);
            ev = 8'h00;
            `CHK(serr_w, m != 0)
            @(negedge clk_in);
            `CHK(serr_w, 1'b1)
            rd(8'h68, (m == 0) ? 32'h1 << (16 + i) : 32'h0);
            acc(1'b1, 8'h68, 4'hf, 32'h0000_0000);
            rd(8'h68, (m == 0) ? 32'h1 << (16 + i) : 32'h0);
            acc(1'b1, 8'h68, 4'h4, 32'h00ff_0000);
            rd(8'h68, 32'h0000_0000);
        end
    end
    $display("test cause_status done");
    // Event and clear land together: set wins, a one clears only its own bit
    @(negedge clk_in);
    {cfg_wr_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = {1'b1, 8'h68, 4'h4, 32'h0080_0000};
    {ev, dis, en} = {8'h81, 8'h00, 1'b1};
    @(negedge clk_in);
    {cfg_wr_in, ev} = 9'h000;
    rd(8'h68, 32'h0081_0000);
    acc(1'b1, 8'h68, 4'h4, 32'h0001_0000);
    rd(8'h68, 32'h0080_0000);
    // Reset in mid-run clears the sticky flags and reloads the options
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    rd(8'h68, 32'h0000_0000);
    rd(8'h74, 32'h0000_0c00);
    $display("test set_wins_and_reset done");
    // Alias enables per port: none, primary pair, secondary pair
    for (m = 0; m < 3; m++) begin
        opt = (m == 0) ? 32'h0 : (m == 1) ? 32'h0000_0006 : 32'h0000_0018;
        acc(1'b1, 8'h74, 4'hf, opt);
        for (p = 0; p < 2; p++) begin
            rt(p, 4'he, 4'h6, opt[1+2*p]);
            rt(p, 4'hc, 4'h6, opt[1+2*p]);
            rt(p, 4'hf, 4'h7, opt[2+2*p]);
            rt(p, 4'h6, 4'h6, 1'b1);
            rt(p, 4'h7, 4'h6, 1'b0);
        end
    end
    $display("test retry_match done");
    rq(0, 32'h0000_0c00, 1'b0, 1'b0, 4);
    rq(0, 32'h0000_0400, 1'b0, 1'b0, 1);
    rq(1, 32'h0000_0400, 1'b0, 1'b0, 4);
    rq(1, 32'h0000_0800, 1'b0, 1'b0, 1);
    rq(1, 32'h0000_0400, 1'b0, 1'b1, 2);
    rq(0, 32'h0000_0200, 1'b1, 1'b0, 4);
    rq(0, 32'h0000_0200, 1'b0, 1'b0, 1);
    $display("test request_hold done");
    print_verdict();
end
endmodule // bridge_error_status_port_options_test
`undef CHK
`default_nettype wire
